// ### hdl/adc_slot_map.vh
`ifndef ADC_SLOT_MAP_VH
`define ADC_SLOT_MAP_VH
// Register byte offsets; the two slot table bases are paddr[7:6] page codes
`define OFS_CLOCK_CTL        8'h00
`define OFS_REFERENCE_CTL    8'h04
`define OFS_SAMPLE_MODE      8'h08
`define OFS_INT_TRIG_SEL     8'h0C
`define OFS_STATUS           8'h10
`define OFS_INT_LINE_SEL     8'h14
`define OFS_SLOT_CFG_BASE    2'b01
`define OFS_SLOT_RESULT_BASE 2'b10
// clock_control_reg fields
`define BIT_CLOCK_HALVE      0
`define BIT_CLOCK_QUARTER    1
`define BIT_NO_OVERLAP       2
// reference_control_reg fields
`define BIT_REF_SELECT       0
`define BIT_INT_LATE         1
// slot_config_reg fields
`define SWL_LSB              0
`define SWL_MSB              5
`define CHS_LSB              6
`define CHS_MSB              9
`define TRG_LSB              10
`define TRG_MSB              14
// Status fields
`define STAT_PTR_LSB         16
`define BIT_ERR_TRIG         20
`define BIT_ERR_CHAN         21
`define BIT_BUSY             22
// Interrupt line select fields
`define INT1_SLOT_LSB        0
`define BIT_INT1_EN          4
`define INT2_SLOT_LSB        8
`define BIT_INT2_EN          12
// Reset values
`define RST_CLOCK_CTL        3'h0
`define RST_REFERENCE_CTL    2'h2
`define RST_SLOT_CFG         15'h1406
`define RST_POINTER          4'hF
// Timing and code ranges
`define CONV_CYCLES          4'hD
`define TRIG_CODE_LO         5'h05
`define TRIG_CODE_HI         5'h14
`define SIMUL_CHAN_MAX       4'h7
`endif

// ### hdl/converter_clock_divider.v
`timescale 1ns/100ps
module converter_clock_divider
(
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Divider selection
   input  wire       halve,
   input  wire       quarter,
   // One system cycle per converter clock
   output reg        tick
);
   reg  [1:0] count_reg;
   wire [1:0] term;

   assign term = halve ? (quarter ? 2'h3 : 2'h1) : 2'h0;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         count_reg <= 2'h0;
         tick      <= 1'b0;
      end
      else
      begin
         // Wrap also covers a divider change that leaves the count above the new end
         tick      <= (count_reg >= term);
         count_reg <= (count_reg >= term) ? 2'h0 : count_reg + 2'h1;
      end
   end
endmodule // converter_clock_divider

// ### hdl/adc_conversion_slot_control.v
`timescale 1ns/100ps
`include "adc_slot_map.vh"
module adc_conversion_slot_control
(
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // APB slave
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [11:0]  paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // PWM start triggers, asynchronous pins
   input  wire [15:0]  pwm_start_trigger,
   // Digitised analog inputs, eight 12-bit words per group
   input  wire [95:0]  group_a_input,
   input  wire [95:0]  group_b_input,
   // Results and events
   output reg  [191:0] slot_result,
   output reg          conversion_end_pulse,
   output reg  [1:0]   conversion_interrupt_line,
   output reg          reference_external
);
   localparam C_IDLE = 2'b00;
   localparam C_RUN  = 2'b01;
   localparam C_EOC  = 2'b10;
   localparam C_INT  = 2'b11;

   reg  [2:0]  clock_control_reg;
   reg  [1:0]  reference_control_reg;
   reg  [7:0]  paired_simultaneous_enable;
   reg  [31:0] int_trig_sel_reg;
   reg  [12:0] int_line_sel_reg;
   reg  [14:0] slot_config_reg [0:15];
   reg  [15:0] pend_reg;
   reg  [3:0]  priority_rotation_pointer;
   reg         err_trig_reg;
   reg         err_chan_reg;
   reg  [15:0] sync1_reg;
   reg  [15:0] sync2_reg;
   reg  [15:0] sync3_reg;
   reg  [15:0] trig_level_reg;
   reg         samp_busy_reg;
   reg         samp_hold_reg;
   reg  [3:0]  samp_slot_reg;
   reg  [5:0]  samp_cnt_reg;
   reg         samp_simul_reg;
   reg  [11:0] samp_a_reg;
   reg  [11:0] samp_b_reg;
   reg  [1:0]  conv_state_reg;
   reg  [3:0]  conv_cnt_reg;
   reg  [3:0]  conv_slot_reg;
   reg  [3:0]  conv_dest_reg;
   reg  [11:0] conv_data_reg;
   reg  [11:0] conv_data_b_reg;
   reg         conv_second_reg;
   reg  [1:0]  int_evt_reg;
   reg  [31:0] rd_data;
   reg         rd_err;
   reg  [15:0] trig_hit;
   reg  [15:0] inflight;
   reg  [1:0]  sel2;
   reg  [4:0]  trg;
   reg  [4:0]  trg_ofs;
   integer     i;
   integer     j;
   integer     m;

   wire        tick;
   wire        setup_ph;
   wire        wr_en;
   wire [15:0] pwm_edge;
   wire [4:0]  pick;
   wire [14:0] pick_cfg;
   wire        pick_simul;
   wire        samp_start;
   wire        conv_load;
   wire        last_latch;
   wire [3:0]  int1_slot;
   wire [3:0]  int2_slot;

   // Round robin search starting one past the pointer
   function [4:0] rr_pick;
      input [15:0] req;
      input [3:0]  ptr;
      integer      k;
      reg   [3:0]  c;
      begin
         rr_pick = 5'h00;
         for (k = 16; k >= 1; k = k - 1)
         begin
            c = ptr + k[3:0];
            if (req[c])
               rr_pick = {1'b1, c};
         end
      end
   endfunction

   // 12-bit word out of a packed group of eight
   function [11:0] word12;
      input [95:0] bus;
      input [2:0]  idx;
      begin
         word12 = bus[idx*12 +: 12];
      end
   endfunction

   converter_clock_divider u_div
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .halve   (clock_control_reg[`BIT_CLOCK_HALVE]),
      .quarter (clock_control_reg[`BIT_CLOCK_QUARTER]),
      .tick    (tick)
   );

   assign setup_ph  = psel & ~penable;
   assign wr_en     = psel & penable & pready & pwrite & ~pslverr;
   assign int1_slot = int_line_sel_reg[`INT1_SLOT_LSB +: 4];
   assign int2_slot = int_line_sel_reg[`INT2_SLOT_LSB +: 4];

   // Register read decode; upper page and gaps answer with an error
   always @*
   begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (paddr[11:8] != 4'h0 || paddr[7:6] == 2'b11)
         rd_err = 1'b1;
      else if (paddr[7:6] == `OFS_SLOT_CFG_BASE)
         rd_data = {17'h0_0000, slot_config_reg[paddr[5:2]]};
      else if (paddr[7:6] == `OFS_SLOT_RESULT_BASE)
         rd_data = {20'h0_0000, slot_result[paddr[5:2]*12 +: 12]};
      else
      begin
         case (paddr[7:0])
            `OFS_CLOCK_CTL:     rd_data = {29'h0000_0000, clock_control_reg};
            `OFS_REFERENCE_CTL: rd_data = {30'h0000_0000, reference_control_reg};
            `OFS_SAMPLE_MODE:   rd_data = {24'h00_0000, paired_simultaneous_enable};
            `OFS_INT_TRIG_SEL:  rd_data = int_trig_sel_reg;
            `OFS_STATUS:        rd_data = {9'h000, (conv_state_reg != C_IDLE), err_chan_reg,
                                           err_trig_reg, priority_rotation_pointer, pend_reg};
            `OFS_INT_LINE_SEL:  rd_data = {19'h0_0000, int_line_sel_reg};
            default:            rd_err  = 1'b1;
         endcase
      end
   end

   // APB answer: one wait-free access phase, read data captured at setup
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setup_ph;
         pslverr <= setup_ph & (rd_err | (pwrite & paddr[7:6] == `OFS_SLOT_RESULT_BASE));
         if (setup_ph && !pwrite)
            prdata <= rd_data;
      end
   end

   // Configuration registers
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         clock_control_reg          <= `RST_CLOCK_CTL;
         reference_control_reg      <= `RST_REFERENCE_CTL;
         paired_simultaneous_enable <= 8'h00;
         int_trig_sel_reg           <= 32'h0000_0000;
         int_line_sel_reg           <= 13'h0000;
         reference_external         <= 1'b0;
         for (i = 0; i < 16; i = i + 1)
            slot_config_reg[i] <= `RST_SLOT_CFG;
      end
      else
      begin
         reference_external <= reference_control_reg[`BIT_REF_SELECT];
         if (wr_en && paddr[7:6] == `OFS_SLOT_CFG_BASE)
            slot_config_reg[paddr[5:2]] <= pwdata[14:0];
         else if (wr_en)
         begin
            case (paddr[7:0])
               `OFS_CLOCK_CTL:     clock_control_reg          <= pwdata[2:0];
               `OFS_REFERENCE_CTL: reference_control_reg      <= pwdata[1:0];
               `OFS_SAMPLE_MODE:   paired_simultaneous_enable <= pwdata[7:0];
               `OFS_INT_TRIG_SEL:  int_trig_sel_reg           <= pwdata;
               `OFS_INT_LINE_SEL:  int_line_sel_reg           <= pwdata[12:0];
               default:            int_line_sel_reg           <= int_line_sel_reg;
            endcase
         end
      end
   end

   // Trigger pins: three stages, a level counts once stages two and three agree
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         sync1_reg      <= 16'h0000;
         sync2_reg      <= 16'h0000;
         sync3_reg      <= 16'h0000;
         trig_level_reg <= 16'h0000;
      end
      else
      begin
         sync1_reg      <= pwm_start_trigger;
         sync2_reg      <= sync1_reg;
         sync3_reg      <= sync2_reg;
         trig_level_reg <= (sync2_reg & sync3_reg) | (trig_level_reg & (sync2_reg | sync3_reg));
      end
   end

   assign pwm_edge = sync2_reg & sync3_reg & ~trig_level_reg;

   // Per-slot trigger; a non-zero interrupt select overrides the source code
   always @*
   begin
      trig_hit = 16'h0000;
      sel2     = 2'b00;
      trg      = 5'h00;
      trg_ofs  = 5'h00;
      for (j = 0; j < 16; j = j + 1)
      begin
         sel2    = int_trig_sel_reg[2*j +: 2];
         trg     = slot_config_reg[j][`TRG_MSB:`TRG_LSB];
         trg_ofs = trg - `TRIG_CODE_LO;
         if (sel2 != 2'b00)
            trig_hit[j] = (sel2 == 2'b01 & int_evt_reg[0]) |
                          (sel2 == 2'b10 & int_evt_reg[1]);
         else if (trg >= `TRIG_CODE_LO && trg <= `TRIG_CODE_HI)
            trig_hit[j] = pwm_edge[trg_ofs[3:0]];
      end
   end

   // Slots already taken by the sampler or the converter are not picked again
   always @*
   begin
      inflight = 16'h0000;
      if (samp_busy_reg || samp_hold_reg)
         inflight[samp_slot_reg] = 1'b1;
      if (conv_state_reg != C_IDLE)
         inflight[conv_slot_reg] = 1'b1;
   end

   assign pick       = rr_pick(pend_reg & ~inflight, priority_rotation_pointer);
   assign pick_cfg   = slot_config_reg[pick[3:0]];
   assign pick_simul = paired_simultaneous_enable[pick[3:1]];
   assign samp_start = pick[4] & ~samp_busy_reg & ~samp_hold_reg &
                       (~clock_control_reg[`BIT_NO_OVERLAP] | conv_state_reg == C_IDLE);
   assign conv_load  = samp_hold_reg & (conv_state_reg == C_IDLE);
   assign last_latch = tick & (conv_state_reg == C_EOC) & ~conv_second_reg;

   // Pending flags, pointer and error flags; a new trigger wins over the clear
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         pend_reg                  <= 16'h0000;
         priority_rotation_pointer <= `RST_POINTER;
         err_trig_reg              <= 1'b0;
         err_chan_reg              <= 1'b0;
      end
      else
      begin
         for (m = 0; m < 16; m = m + 1)
            if (trig_hit[m])
               pend_reg[m] <= 1'b1;
            else if (last_latch && conv_slot_reg == m[3:0])
               pend_reg[m] <= 1'b0;
         if (last_latch)
            priority_rotation_pointer <= conv_slot_reg;
         if (wr_en && paddr[7:6] == `OFS_SLOT_CFG_BASE &&
             (pwdata[`TRG_MSB:`TRG_LSB] < `TRIG_CODE_LO ||
              pwdata[`TRG_MSB:`TRG_LSB] > `TRIG_CODE_HI))
            err_trig_reg <= 1'b1;
         else if (wr_en && paddr[7:0] == `OFS_STATUS && pwdata[`BIT_ERR_TRIG])
            err_trig_reg <= 1'b0;
         if (samp_start && pick_simul && pick_cfg[`CHS_MSB:`CHS_LSB] > `SIMUL_CHAN_MAX)
            err_chan_reg <= 1'b1;
         else if (wr_en && paddr[7:0] == `OFS_STATUS && pwdata[`BIT_ERR_CHAN])
            err_chan_reg <= 1'b0;
      end
   end

   // Sampler: window of length plus one converter clocks, begin/end average
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         samp_busy_reg  <= 1'b0;
         samp_hold_reg  <= 1'b0;
         samp_slot_reg  <= 4'h0;
         samp_cnt_reg   <= 6'h00;
         samp_simul_reg <= 1'b0;
         samp_a_reg     <= 12'h000;
         samp_b_reg     <= 12'h000;
      end
      else if (samp_start)
      begin
         samp_busy_reg  <= 1'b1;
         samp_slot_reg  <= pick[3:0];
         samp_cnt_reg   <= pick_cfg[`SWL_MSB:`SWL_LSB];
         samp_simul_reg <= pick_simul;
         if (pick_simul)
            samp_a_reg <= word12(group_a_input, pick_cfg[`CHS_LSB +: 3]);
         else if (pick_cfg[`CHS_MSB])
            samp_a_reg <= word12(group_b_input, pick_cfg[`CHS_LSB +: 3]);
         else
            samp_a_reg <= word12(group_a_input, pick_cfg[`CHS_LSB +: 3]);
         samp_b_reg <= word12(group_b_input, pick_cfg[`CHS_LSB +: 3]);
      end
      else if (samp_busy_reg && tick)
      begin
         if (samp_cnt_reg == 6'h00)
         begin
            // Average of the two ends stands in for the charging capacitor
            samp_busy_reg <= 1'b0;
            samp_hold_reg <= 1'b1;
            if (samp_simul_reg)
               samp_a_reg <= avg12(samp_a_reg,
                                   word12(group_a_input, sel_chan(samp_slot_reg)));
            else if (slot_config_reg[samp_slot_reg][`CHS_MSB])
               samp_a_reg <= avg12(samp_a_reg,
                                   word12(group_b_input, sel_chan(samp_slot_reg)));
            else
               samp_a_reg <= avg12(samp_a_reg,
                                   word12(group_a_input, sel_chan(samp_slot_reg)));
            samp_b_reg <= avg12(samp_b_reg, word12(group_b_input, sel_chan(samp_slot_reg)));
         end
         else
            samp_cnt_reg <= samp_cnt_reg - 6'h01;
      end
      else if (conv_load)
         samp_hold_reg <= 1'b0;
   end

   function [2:0] sel_chan;
      input [3:0] slot;
      begin
         sel_chan = slot_config_reg[slot][`CHS_LSB +: 3];
      end
   endfunction

   function [11:0] avg12;
      input [11:0] a;
      input [11:0] b;
      reg   [12:0] s;
      begin
         s     = {1'b0, a} + {1'b0, b};
         avg12 = s[12:1];
      end
   endfunction

   // Converter: thirteen clocks, end pulse, then latch with interrupt pulse
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         conv_state_reg            <= C_IDLE;
         conv_cnt_reg              <= 4'h0;
         conv_slot_reg             <= 4'h0;
         conv_dest_reg             <= 4'h0;
         conv_data_reg             <= 12'h000;
         conv_data_b_reg           <= 12'h000;
         conv_second_reg           <= 1'b0;
         slot_result               <= 192'h0;
         conversion_end_pulse      <= 1'b0;
         conversion_interrupt_line <= 2'b00;
         int_evt_reg               <= 2'b00;
      end
      else
      begin
         int_evt_reg <= 2'b00;
         case (conv_state_reg)
            C_IDLE:
            begin
               if (conv_load)
               begin
                  conv_state_reg  <= C_RUN;
                  conv_cnt_reg    <= 4'h0;
                  conv_slot_reg   <= samp_slot_reg;
                  conv_dest_reg   <= samp_slot_reg;
                  conv_data_reg   <= samp_a_reg;
                  conv_data_b_reg <= samp_b_reg;
                  conv_second_reg <= samp_simul_reg;
               end
            end
            C_RUN:
            begin
               if (tick)
               begin
                  conv_cnt_reg <= conv_cnt_reg + 4'h1;
                  if (conv_cnt_reg == `CONV_CYCLES - 4'h1)
                  begin
                     conv_state_reg       <= C_EOC;
                     conversion_end_pulse <= 1'b1;
                  end
               end
            end
            C_EOC:
            begin
               if (tick)
               begin
                  // Whole word in one edge, so no partial result is ever seen
                  slot_result[conv_dest_reg*12 +: 12] <= conv_data_reg;
                  conversion_end_pulse <= 1'b0;
                  conversion_interrupt_line[0] <= int_line_sel_reg[`BIT_INT1_EN] &
                                                  (int1_slot == conv_dest_reg);
                  conversion_interrupt_line[1] <= int_line_sel_reg[`BIT_INT2_EN] &
                                                  (int2_slot == conv_dest_reg);
                  int_evt_reg[0] <= int_line_sel_reg[`BIT_INT1_EN] &
                                    (int1_slot == conv_dest_reg);
                  int_evt_reg[1] <= int_line_sel_reg[`BIT_INT2_EN] &
                                    (int2_slot == conv_dest_reg);
                  conv_state_reg <= C_INT;
               end
            end
            default:
            begin
               if (tick)
               begin
                  conversion_interrupt_line <= 2'b00;
                  if (conv_second_reg)
                  begin
                     // Partner slot of the pair receives the group B result
                     conv_state_reg  <= C_RUN;
                     conv_cnt_reg    <= 4'h0;
                     conv_dest_reg   <= conv_slot_reg ^ 4'h1;
                     conv_data_reg   <= conv_data_b_reg;
                     conv_second_reg <= 1'b0;
                  end
                  else
                     conv_state_reg <= C_IDLE;
               end
            end
         endcase
      end
   end
endmodule // adc_conversion_slot_control

// ### bench/adc_slot_checker_asserts.sv
`timescale 1ns/100ps
module adc_slot_checker
(
   // Clock and reset
   input wire         clk,
   input wire         rst_n,
   // APB
   input wire         psel,
   input wire         penable,
   input wire         pwrite,
   input wire [11:0]  paddr,
   input wire [31:0]  pwdata,
   input wire [31:0]  prdata,
   input wire         pready,
   input wire         pslverr,
   // Results and events
   input wire [191:0] slot_result,
   input wire         conversion_end_pulse,
   input wire [1:0]   conversion_interrupt_line,
   input wire         reference_external
);
   reg  [2:0] div_reg;
   reg  [2:0] eoc_len_reg;
   wire       acc = psel && penable && pready;
   wire [2:0] width = !div_reg[0] ? 3'h1 : (div_reg[1] ? 3'h4 : 3'h2);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Shadow of the divider bits, so pulse widths can be judged per setting
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         div_reg     <= 3'h0;
         eoc_len_reg <= 3'h0;
      end
      else
      begin
         if (acc && pwrite && paddr == 12'h000)
            div_reg <= pwdata[2:0];
         eoc_len_reg <= conversion_end_pulse ? eoc_len_reg + 3'h1 : 3'h0;
      end
   end
   AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   AST_PREADY_ONLY_ACCESS: assert property (pready |-> $past(psel && !penable) && penable)
      else $error("pready outside access");
   AST_RESULT_WRITE_REFUSED: assert property (psel && !penable && pwrite && paddr[11:6] == 6'h02
      |=> pslverr)
      else $error("result write not refused");
   AST_UNMAPPED_READ_ZERO: assert property (psel && !penable && !pwrite && paddr[11:8] != 4'h0
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   AST_REF_FOLLOWS_WRITE: assert property (acc && pwrite && paddr == 12'h004
      |=> ##1 reference_external == $past(pwdata[0], 2))
      else $error("reference select not followed");
   AST_RESULT_AT_LATCH: assert property (slot_result != $past(slot_result)
      |-> $fell(conversion_end_pulse))
      else $error("result changed outside latch");
   AST_INT_WITH_LATCH: assert property ($rose(|conversion_interrupt_line)
      |-> $fell(conversion_end_pulse))
      else $error("interrupt not with latch");
   AST_EOC_WIDTH: assert property ($fell(conversion_end_pulse) |-> eoc_len_reg == width)
      else $error("end pulse width wrong");
   AST_INT_WIDTH: assert property ($rose(conversion_interrupt_line[0]) && width == 3'h1
      |=> !conversion_interrupt_line[0])
      else $error("interrupt width wrong");
   cover property ($fell(conversion_end_pulse));
   cover property ($rose(conversion_interrupt_line[0]));
   cover property (pready && pslverr);
endmodule // adc_slot_checker
bind adc_conversion_slot_control adc_slot_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .slot_result(slot_result),
   .conversion_end_pulse(conversion_end_pulse),
   .conversion_interrupt_line(conversion_interrupt_line),
   .reference_external(reference_external));

// ### bench/pwm_source_model.sv
`timescale 1ns/100ps
module pwm_source_model
(
   // Clock
   input  wire        clk,
   // Toward the block
   output reg  [15:0] pwm_start_trigger,
   output reg  [95:0] group_a_input,
   output reg  [95:0] group_b_input
);
   integer n;
   initial
   begin
      pwm_start_trigger = 16'h0000;
      for (n = 0; n < 8; n = n + 1)
      begin
         group_a_input[n*12+:12] = (n == 7) ? 12'hFFF : 12'hA00 + n[11:0];
         group_b_input[n*12+:12] = 12'hB00 + n[11:0];
      end
   end
   // Held four cycles so the three-stage synchroniser cannot miss it
   task fire(input [15:0] m);
   begin
      @(posedge clk);
      pwm_start_trigger <= m;
      repeat (4) @(posedge clk);
      pwm_start_trigger <= 16'h0000;
   end
   endtask
endmodule // pwm_source_model

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   reg          clk;
   reg          rst_n;
   reg          psel;
   reg          penable;
   reg          pwrite;
   reg  [11:0]  paddr;
   reg  [31:0]  pwdata;
   wire [31:0]  prdata;
   wire         pready;
   wire         pslverr;
   wire [15:0]  trig;
   wire [95:0]  ain;
   wire [95:0]  bin;
   wire [191:0] res;
   wire         eoc;
   wire [1:0]   irq;
   wire         ref_ext;
   integer      num_errors;
   integer      n_compared;
   integer      cycles;
   integer      irq_seen;
   integer      k;
   integer      t0;
   integer      t1;
   integer      sp [0:1];
   reg  [31:0]  rd;
   reg          err;
   adc_conversion_slot_control u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwm_start_trigger(trig), .group_a_input(ain), .group_b_input(bin),
      .slot_result(res), .conversion_end_pulse(eoc), .conversion_interrupt_line(irq),
      .reference_external(ref_ext));
   pwm_source_model u_src (.clk(clk), .pwm_start_trigger(trig), .group_a_input(ain),
      .group_b_input(bin));
   function [31:0] cfg(input [4:0] tg, input [3:0] ch, input [5:0] ln);
      cfg = {17'h0, tg, ch, ln};
   endfunction
   function [31:0] rs(input integer s);
      rs = {20'h0, res[s*12+:12]};
   endfunction
   function [31:0] aw(input integer n);
      aw = (n == 7) ? 32'h0000_0FFF : 32'h0000_0A00 + n;
   endfunction
   task tally_and_finish;
   begin
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task check(input [79:0] nm, input [31:0] exp, input [31:0] got);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("ERROR %0s expected %h seen %h", nm, exp, got);
      end
   end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task wait_eoc(output integer t);
   begin
      t = 0;
      do
      begin
         @(posedge clk);
         t = t + 1;
      end
      while (eoc !== 1'b1 && t < 2000);
      if (t >= 2000)
         check("eoc", 32'h1, eoc);
   end
   endtask
   task shot(input [15:0] m, output integer t);
   begin
      u_src.fire(m);
      wait_eoc(t);
      repeat (10) @(posedge clk);
   end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // A stuck handshake or conversion ends the run here
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (irq[0] === 1'b1)
         irq_seen = irq_seen + 1;
      if (irq[1] === 1'b1)
         irq_seen = irq_seen + 16;
      if (cycles == 40000)
      begin
         num_errors = num_errors + 1;
         tally_and_finish;
      end
   end
   initial
   begin
      {num_errors, n_compared, cycles, irq_seen} = 128'h0;
      {psel, penable, pwrite, paddr, pwdata} = 47'h0;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, 12'h000, 0); check("clk_ctl", 32'h0, rd);
      apb(0, 12'h004, 0); check("ref_ctl", 32'h0000_0002, rd);
      apb(0, 12'h040, 0); check("slot_cfg", 32'h0000_1406, rd);
      apb(0, 12'h010, 0); check("status", 32'h000F_0000, rd);
      apb(0, 12'h018, 0); check("unmapped", 32'h1, err);
      apb(0, 12'h100, 0);
      apb(1, 12'h080, 32'h0000_0005); check("res_write", 32'h1, err);
      apb(1, 12'h004, 32'h0000_0003);
      repeat (2) @(posedge clk);
      check("ref_ext", 32'h1, ref_ext);
      apb(1, 12'h004, 32'h0000_0002);
      for (k = 0; k < 16; k = k + 1)
      begin
         apb(1, 12'(64 + 4 * k), cfg(5'(20 - k), 4'(k), 6'h06));
         shot(16'h8000 >> k, t0);
         check("result", (k < 8) ? aw(k) : 32'h0000_0AF8 + k, rs(k));
      end
      shot(16'h8000, t0);
      check("conv_time", 32'h1, t0 >= 18 && t0 <= 26);
      apb(1, 12'h040, cfg(5'h14, 4'h0, 6'h09));
      shot(16'h8000, t1);
      check("window", 32'h3, t1 - t0);
      apb(1, 12'h000, 32'h0000_0001);
      shot(16'h8000, t0);
      check("halve", 32'h1, t0 - t1 >= 21 && t0 - t1 <= 26);
      apb(1, 12'h000, 32'h0000_0003);
      shot(16'h8000, t0);
      check("quarter", 32'h1, t0 - t1 >= 65 && t0 - t1 <= 68);
      apb(1, 12'h000, 32'h0000_0000);
      apb(1, 12'h008, 32'h0000_0004);
      apb(1, 12'h050, cfg(5'h10, 4'hB, 6'h06));
      shot(16'h0800, t0);
      repeat (30) @(posedge clk);
      check("simul_a", aw(3), rs(4));
      check("simul_b", 32'h0000_0B03, rs(5));
      apb(0, 12'h010, 0); check("chan_err", 32'h1, rd[21]);
      apb(1, 12'h010, 32'h0020_0000);
      apb(1, 12'h008, 32'h0000_0000);
      for (k = 0; k < 2; k = k + 1)
      begin
         apb(1, 12'h058, cfg(k ? 5'h15 : 5'h04, 4'h6, 6'h06));
         apb(0, 12'h010, 0); check("trig_err", 32'h1, rd[20]);
         apb(1, 12'h010, 32'h0010_0000);
         apb(0, 12'h010, 0); check("trig_clr", 32'h0, rd[20]);
      end
      for (k = 0; k < 2; k = k + 1)
      begin
         apb(1, 12'h000, k * 4);
         u_src.fire(16'hC000);
         wait_eoc(t0);
         wait_eoc(sp[k]);
         repeat (10) @(posedge clk);
      end
      check("overlap", 32'h1, sp[1] >= sp[0] + 7);
      check("conv_gap", 32'h1, sp[0] >= 13);
      shot(16'h0100, t0);
      apb(0, 12'h010, 0); check("ptr7", 32'h0007_0000, rd);
      apb(1, 12'h048, cfg(5'h12, 4'hA, 6'h06));
      apb(1, 12'h070, cfg(5'h08, 4'hC, 6'h06));
      apb(1, 12'h064, cfg(5'h0B, 4'hF, 6'h06));
      apb(1, 12'h014, 32'h0000_121C);
      apb(1, 12'h00C, 32'h0004_0000);
      u_src.fire(16'h2008);
      apb(0, 12'h010, 0); check("pending", 32'h0000_1004, rd[15:0]);
      wait_eoc(t0);
      repeat (10) @(posedge clk);
      check("rr_first", 32'h0000_0B04, rs(12));
      check("rr_wait", aw(2), rs(2));
      apb(0, 12'h010, 0); check("ptr12", 32'hC, rd[19:16]);
      wait_eoc(t0);
      repeat (10) @(posedge clk);
      check("rr_second", 32'h0000_0B02, rs(2));
      wait_eoc(t0);
      repeat (10) @(posedge clk);
      check("int_trig", 32'h0000_0B07, rs(9));
      check("irq_line", 32'h11, irq_seen);
      apb(0, 12'h010, 0); check("pend_clr", 32'h0, rd[15:0]);
      tally_and_finish;
   end
endmodule // tb_top
